// [hspc_defs.svh]
// Register offsets, field positions, reset values and limits of the Hall sensor position counter
`ifndef HSPC_DEFS_SVH
`define HSPC_DEFS_SVH

`define HSPC_ADDR_W 8
`define HSPC_OFF_CTRL 8'h00
`define HSPC_OFF_CMD 8'h04
`define HSPC_OFF_COMPARE 8'h08
`define HSPC_OFF_RELOAD 8'h0C
`define HSPC_OFF_COUNTER 8'h10
`define HSPC_OFF_CAPTURE 8'h14
`define HSPC_OFF_STATUS 8'h18

`define HSPC_CTRL_RUN 0
`define HSPC_CTRL_MODE_LO 1
`define HSPC_CTRL_MODE_HI 2
`define HSPC_CTRL_THREE_PH 3
`define HSPC_CTRL_ZEN 4
`define HSPC_CTRL_ZESEL 5
`define HSPC_CTRL_CMPEN 6
`define HSPC_CTRL_POUT_EN 7
`define HSPC_CTRL_DIV_LSB 8
`define HSPC_CMD_CLEAR 0
`define HSPC_CMD_SFTCAP 1
`define HSPC_STAT_DIR 0
`define HSPC_STAT_REVERSE_ERROR_FLAG 1

`define HSPC_MODE_ENC 2'h0
`define HSPC_MODE_EVT 2'h1
`define HSPC_MODE_STC 2'h2
`define HSPC_MODE_TMR 2'h3

`define HSPC_RST_COMPARE 24'h000000
`define HSPC_RST_RELOAD 16'hFFFF
`define HSPC_RST_DIV 8'h00
`define HSPC_CNT16_MAX 16'hFFFF
`define HSPC_CNT24_MAX 24'hFFFFFF
`define HSPC_PH2_LEN 3'h4
`define HSPC_PH3_LEN 3'h6
`define HSPC_PH_BAD 3'h7

`define HSPC_RESP_OKAY 2'h0
`define HSPC_RESP_SLVERR 2'h2

`endif

// [hspc_pkg.sv]
// Types shared by the Hall sensor position counter modules
`include "hspc_defs.svh"

package hspc_pkg;

  typedef struct packed {
    logic [2:0] prev_idx;
    logic pulse;
    logic cw;
  } hspc_dec_state_t;

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] pins;
    logic z_prev;
    logic run;
    logic [1:0] mode;
    logic three_ph;
    logic zen;
    logic zesel;
    logic cmpen;
    logic pout_en;
    logic [7:0] div_factor;
    logic [23:0] compare;
    logic [15:0] reload;
    logic [23:0] cnt;
    logic [23:0] capture;
    logic dir_flag;
    logic last_dir;
    logic rev_err;
    logic [7:0] div_cnt;
    logic div_pulse;
    logic irq;
    logic aw_got;
    logic [`HSPC_ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hspc_state_t;

endpackage

// [hspc_phase_dec.sv]
// Phase decoder: turns Hall or quadrature levels into rotation pulses and a direction
`timescale 1ns/1ps
`default_nettype none
`include "hspc_defs.svh"

module hspc_phase_dec import hspc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic u_i,
  input wire logic v_i,
  input wire logic w_i,
  input wire logic three_phase_enable_i,
  output logic rotation_pulse_o,
  output logic cw_o
);

  hspc_dec_state_t s;
  hspc_dec_state_t next_s;

  // Position of the input pattern in the clockwise sequence, bad code for an illegal pattern
  function automatic logic [2:0] phase_index(input logic u, input logic v, input logic w, input logic three);
    logic [2:0] idx;
    idx = `HSPC_PH_BAD;
    if (three) begin
      unique case ({u, v, w})
        3'h1: idx = 3'h0;
        3'h5: idx = 3'h1;
        3'h4: idx = 3'h2;
        3'h6: idx = 3'h3;
        3'h2: idx = 3'h4;
        3'h3: idx = 3'h5;
        default: idx = `HSPC_PH_BAD;
      endcase
    end else begin
      unique case ({u, v})
        2'h0: idx = 3'h0;
        2'h2: idx = 3'h1;
        2'h3: idx = 3'h2;
        2'h1: idx = 3'h3;
      endcase
    end
    return idx;
  endfunction

  logic [2:0] cur_idx;
  logic [2:0] seq_len;
  logic [2:0] fwd_idx;
  logic [2:0] back_idx;

  always_comb begin
    next_s = s;
    cur_idx = phase_index(u_i, v_i, w_i, three_phase_enable_i);
    seq_len = three_phase_enable_i ? `HSPC_PH3_LEN : `HSPC_PH2_LEN;
    fwd_idx = (s.prev_idx == seq_len - 3'h1) ? 3'h0 : s.prev_idx + 3'h1;
    back_idx = (s.prev_idx == 3'h0) ? seq_len - 3'h1 : s.prev_idx - 3'h1;
    next_s.pulse = 1'b0;
    // Each legal step of the sequence is one pulse: 4 per cycle on two phases, 6 on three
    if (cur_idx != `HSPC_PH_BAD && s.prev_idx != `HSPC_PH_BAD && cur_idx != s.prev_idx) begin
      if (cur_idx == fwd_idx) begin
        next_s.pulse = 1'b1;
        next_s.cw = 1'b1;
      end else if (cur_idx == back_idx) begin
        next_s.pulse = 1'b1;
        next_s.cw = 1'b0;
      end
    end
    next_s.prev_idx = cur_idx;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{prev_idx: `HSPC_PH_BAD, pulse: 1'b0, cw: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign rotation_pulse_o = s.pulse;
  assign cw_o = s.cw;

endmodule // hspc_phase_dec
`default_nettype wire

// [hspc_top.sv]
// Hall sensor position and interval counter with AXI4-Lite registers
//
// Operation
// - Rotation pulse: four steps per cycle from U,V; six from U,V,W when three-phase.
// - Event count, clockwise: counter increments per pulse, wraps 0xFFFF to zero.
// - Event count, counter-clockwise: counter decrements per pulse, wraps 0x0000 to 0xFFFF.
// - Direction flag reads 1 while clockwise, 0 while counter-clockwise.
// - Writing 1 to the clear bit zeroes the counter in every mode.
// - Divided pulse output is the rotation pulse divided by the programmed factor plus one.
// - Event count with compare enabled: interrupt when counter equals compare value.
// - Sensor timer count: counts up, clears on each pulse, wraps after 0xFFFFFF.
// - Sensor timer count: each pulse copies counter into the capture register.
// - Software capture bit copies counter into capture in sensor timer and timer modes.
// - Sensor timer count: reverse-error flag sets on direction change, clears on read.
// - Capture register ignores the run bit; only reset clears it.
// - Writing run bit 0 clears the direction flag.
// - Timer mode: Z is an external trigger only when Z enable is 1.
// - Timer mode with Z: clear on rising or falling edge per select; wrap after 0xFFFFFF.
// - Timer mode: selected Z edge copies counter into capture register.
// - Timer mode with compare enabled: interrupt when counter reaches compare value.
// - Timer mode: also clears on software clear, at 0xFFFFFF, or on compare match when compare is enabled.
// - Counting down in encoder mode, 0x0000 reloads on next pulse; event mode wraps it to 0xFFFF.
// - Run bit 0 holds the counter; run bit 1 resumes; only clear zeroes it.
// - Position counter is one 24-bit register; up/down counting uses its low 16 bits.
// - Timer mode counter increments every system clock cycle.
`timescale 1ns/1ps
`default_nettype none
`include "hspc_defs.svh"

module hspc_top import hspc_pkg::*; (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic ENC_U_I,
  input wire logic ENC_V_I,
  input wire logic ENC_W_I,
  input wire logic ENC_Z_I,
  output logic DIV_PULSE_O,
  output logic DIRECTION_O,
  output logic IRQ_O,
  input wire logic [`HSPC_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [`HSPC_ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);

  hspc_state_t s;
  hspc_state_t next_s;
  logic rot_pulse;
  logic rot_cw;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Phase decoding on synchronised pins

  // Three-phase enable is trusted to match the wiring; set on two-phase wiring, a cycle gives 2 pulses; clear on three-phase, a cycle gives 4 pulses
  hspc_phase_dec u_dec (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .u_i(s.pins[0]),
    .v_i(s.pins[1]),
    .w_i(s.pins[2]),
    .three_phase_enable_i(s.three_ph),
    .rotation_pulse_o(rot_pulse),
    .cw_o(rot_cw)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic wr_go;
  logic clr;
  logic sftcap;
  logic rd_status;
  logic z_edge;
  logic z_dir_edge;
  logic stepped;
  logic [23:0] n_cnt;
  logic [31:0] ctrl_word;
  logic [31:0] merged;

  always_comb begin
    next_s = s;
    clr = 1'b0;
    sftcap = 1'b0;
    rd_status = 1'b0;
    stepped = 1'b0;
    merged = 32'h0000_0000;
    ctrl_word = {16'h0000, s.div_factor, s.pout_en, s.cmpen, s.zesel, s.zen, s.three_ph, s.mode, s.run};
    // Pins cross into this clock through two flops; only the second stage is used
    next_s.meta = {ENC_Z_I, ENC_W_I, ENC_V_I, ENC_U_I};
    next_s.pins = s.meta;
    next_s.z_prev = s.pins[3];
    // Timer trigger edge chosen by select bit, encoder clear edge by direction
    z_edge = s.zesel ? (s.z_prev & ~s.pins[3]) : (~s.z_prev & s.pins[3]);
    z_dir_edge = rot_cw ? (~s.z_prev & s.pins[3]) : (s.z_prev & ~s.pins[3]);

    // Write channel: address and data taken in either order
    if (S_AXI_AWVALID_I && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = S_AXI_WDATA_I;
      next_s.wstrb = S_AXI_WSTRB_I;
    end
    if (s.bvalid && S_AXI_BREADY_I) begin
      next_s.bvalid = 1'b0;
    end
    wr_go = s.aw_got && s.w_got && !s.bvalid;
    if (wr_go) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `HSPC_RESP_OKAY;
      unique case (s.awaddr)
        `HSPC_OFF_CTRL: begin
          merged = merge_bytes(ctrl_word, s.wdata, s.wstrb);
          next_s.run = merged[`HSPC_CTRL_RUN];
          next_s.mode = merged[`HSPC_CTRL_MODE_HI:`HSPC_CTRL_MODE_LO];
          next_s.three_ph = merged[`HSPC_CTRL_THREE_PH];
          next_s.zen = merged[`HSPC_CTRL_ZEN];
          next_s.zesel = merged[`HSPC_CTRL_ZESEL];
          next_s.cmpen = merged[`HSPC_CTRL_CMPEN];
          next_s.pout_en = merged[`HSPC_CTRL_POUT_EN];
          next_s.div_factor = merged[`HSPC_CTRL_DIV_LSB +: 8];
        end
        `HSPC_OFF_CMD: begin
          clr = s.wstrb[0] & s.wdata[`HSPC_CMD_CLEAR];
          sftcap = s.wstrb[0] & s.wdata[`HSPC_CMD_SFTCAP];
        end
        `HSPC_OFF_COMPARE: begin
          merged = merge_bytes({8'h00, s.compare}, s.wdata, s.wstrb);
          next_s.compare = merged[23:0];
        end
        `HSPC_OFF_RELOAD: begin
          merged = merge_bytes({16'h0000, s.reload}, s.wdata, s.wstrb);
          next_s.reload = merged[15:0];
        end
        default: next_s.bresp = `HSPC_RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    // Read channel: one read at a time, answer one cycle after the address
    if (s.rvalid && S_AXI_RREADY_I) begin
      next_s.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `HSPC_RESP_OKAY;
      unique case (S_AXI_ARADDR_I)
        `HSPC_OFF_CTRL: next_s.rdata = ctrl_word;
        `HSPC_OFF_CMD: next_s.rdata = 32'h0000_0000;
        `HSPC_OFF_COMPARE: next_s.rdata = {8'h00, s.compare};
        `HSPC_OFF_RELOAD: next_s.rdata = {16'h0000, s.reload};
        // Upper counter byte is meaningless in the 16-bit modes and reads zero
        `HSPC_OFF_COUNTER: next_s.rdata = {8'h00, (s.mode[1] ? s.cnt[23:16] : 8'h00), s.cnt[15:0]};
        `HSPC_OFF_CAPTURE: next_s.rdata = {8'h00, s.capture};
        `HSPC_OFF_STATUS: begin
          next_s.rdata = {30'h0000_0000, s.rev_err, s.dir_flag};
          rd_status = 1'b1;
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = `HSPC_RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // Counter; held while run is 0 and resumes from the held value
    n_cnt = s.cnt;
    if (s.run) begin
      unique case (s.mode)
        `HSPC_MODE_ENC: begin
          if (s.zen && z_dir_edge) begin
            n_cnt = 24'h000000;
          end else if (rot_pulse) begin
            stepped = 1'b1;
            if (rot_cw) begin
              n_cnt = (s.cnt[15:0] == s.reload) ? 24'h000000 : {8'h00, s.cnt[15:0] + 16'h0001};
            end else begin
              n_cnt = (s.cnt[15:0] == 16'h0000) ? {8'h00, s.reload} : {8'h00, s.cnt[15:0] - 16'h0001};
            end
          end
        end
        `HSPC_MODE_EVT: begin
          if (rot_pulse) begin
            stepped = 1'b1;
            if (rot_cw) begin
              n_cnt = (s.cnt[15:0] == `HSPC_CNT16_MAX) ? 24'h000000 : {8'h00, s.cnt[15:0] + 16'h0001};
            end else begin
              n_cnt = (s.cnt[15:0] == 16'h0000) ? {8'h00, `HSPC_CNT16_MAX} : {8'h00, s.cnt[15:0] - 16'h0001};
            end
          end
        end
        `HSPC_MODE_STC: begin
          stepped = 1'b1;
          if (rot_pulse) begin
            n_cnt = 24'h000000;
            next_s.capture = s.cnt;
          end else begin
            n_cnt = (s.cnt == `HSPC_CNT24_MAX) ? 24'h000000 : s.cnt + 24'h000001;
          end
        end
        `HSPC_MODE_TMR: begin
          stepped = 1'b1;
          // Z has no effect at all unless enabled
          if (s.zen && z_edge) begin
            n_cnt = 24'h000000;
            next_s.capture = s.cnt;
          end else if (s.cmpen && s.cnt == s.compare) begin
            n_cnt = 24'h000000;
          end else begin
            n_cnt = (s.cnt == `HSPC_CNT24_MAX) ? 24'h000000 : s.cnt + 24'h000001;
          end
        end
      endcase
    end
    if (clr) begin
      n_cnt = 24'h000000;
    end
    next_s.cnt = n_cnt;
    // Capture is written only here and by the mode events above, never by run or clear
    if (sftcap && s.mode[1]) begin
      next_s.capture = s.cnt;
    end
    // Match is flagged on the step that lands on the compare value, so a parked counter rings once
    next_s.irq = s.cmpen && stepped && !clr && (n_cnt == s.compare);

    // Direction and reverse error; an event on the read cycle wins over the clear
    if (rd_status) begin
      next_s.rev_err = 1'b0;
    end
    if (s.run && rot_pulse) begin
      next_s.dir_flag = rot_cw;
      next_s.last_dir = rot_cw;
      if (s.mode == `HSPC_MODE_STC && rot_cw != s.last_dir) begin
        next_s.rev_err = 1'b1;
      end
    end
    if (wr_go && s.awaddr == `HSPC_OFF_CTRL && !next_s.run) begin
      next_s.dir_flag = 1'b0;
    end

    // Divider: one output pulse every div_factor+1 rotation pulses
    next_s.div_pulse = 1'b0;
    if (s.run && rot_pulse) begin
      if (s.div_cnt >= s.div_factor) begin
        next_s.div_cnt = 8'h00;
        next_s.div_pulse = s.pout_en;
      end else begin
        next_s.div_cnt = s.div_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      next_s_reset_guard: begin
        s <= '0;
        s.compare <= `HSPC_RST_COMPARE;
        s.reload <= `HSPC_RST_RELOAD;
        s.div_factor <= `HSPC_RST_DIV;
        s.last_dir <= 1'b1;
        s.awready <= 1'b1;
        s.wready <= 1'b1;
        s.arready <= 1'b1;
      end
    end else begin
      s <= next_s;
    end
  end

  assign DIV_PULSE_O = s.div_pulse;
  assign DIRECTION_O = s.dir_flag;
  assign IRQ_O = s.irq;
  assign S_AXI_AWREADY_O = s.awready;
  assign S_AXI_WREADY_O = s.wready;
  assign S_AXI_BRESP_O = s.bresp;
  assign S_AXI_BVALID_O = s.bvalid;
  assign S_AXI_ARREADY_O = s.arready;
  assign S_AXI_RDATA_O = s.rdata;
  assign S_AXI_RRESP_O = s.rresp;
  assign S_AXI_RVALID_O = s.rvalid;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);

  a_event_wrap_up: assert property (
    s.run && s.mode == `HSPC_MODE_EVT && rot_pulse && rot_cw && s.cnt[15:0] == 16'hFFFF && !clr
    |=> s.cnt == 24'h000000)
    else $error("event count did not wrap up to zero");

  a_event_wrap_down: assert property (
    s.run && s.mode == `HSPC_MODE_EVT && rot_pulse && !rot_cw && s.cnt == 24'h000000 && !clr
    |=> s.cnt == 24'h00FFFF)
    else $error("event count did not wrap down to 0xFFFF");

  a_soft_clear: assert property (clr |=> s.cnt == 24'h000000)
    else $error("software clear left counter nonzero");

  a_stop_hold: assert property (!s.run && !clr |=> $stable(s.cnt))
    else $error("counter moved while stopped");

  a_pulse_capture: assert property (
    s.run && s.mode == `HSPC_MODE_STC && rot_pulse && !clr
    |=> s.cnt == 24'h000000 && s.capture == $past(s.cnt))
    else $error("sensor timer pulse did not capture and clear");

  a_timer_count: assert property (
    s.run && s.mode == `HSPC_MODE_TMR && !clr && !(s.zen && z_edge) && !(s.cmpen && s.cnt == s.compare)
    && s.cnt != 24'hFFFFFF |=> s.cnt == $past(s.cnt) + 24'h000001)
    else $error("timer did not count by one");

  a_run_off_dir: assert property (
    wr_go && s.awaddr == `HSPC_OFF_CTRL && !next_s.run |=> !DIRECTION_O)
    else $error("direction flag not cleared on stop");

  a_reverse_set: assert property (
    s.run && s.mode == `HSPC_MODE_STC && rot_pulse && rot_cw != s.last_dir |=> s.rev_err)
    else $error("reverse error not raised");

  a_irq_match: assert property (IRQ_O |-> s.cnt == s.compare && s.cmpen)
    else $error("interrupt without compare match");

  a_cap_hold: assert property (
    !rot_pulse && !sftcap && !(s.zen && z_edge) |=> $stable(s.capture))
    else $error("capture changed without a capture event");

  c_event_wrap: cover property (s.mode == `HSPC_MODE_EVT && s.cnt == 24'h00FFFF ##1 s.cnt == 24'h000000);
  c_irq: cover property (IRQ_O);
  c_z_capture: cover property (s.run && s.mode == `HSPC_MODE_TMR && s.zen && z_edge);
  c_reverse: cover property (s.rev_err);

endmodule // hspc_top
`default_nettype wire

// [hspc_hall_model.sv]
// Hall sensor model that steps U,V,W through the rotation pattern
`timescale 1ns/1ps
`default_nettype none

module hspc_hall_model (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic cw_i,
  input wire logic three_ph_i,
  output logic u_o,
  output logic v_o,
  output logic w_o
);
  localparam logic [2:0] P2 [4] = '{3'h0, 3'h4, 3'h6, 3'h2};
  localparam logic [2:0] P3 [6] = '{3'h1, 3'h5, 3'h4, 3'h6, 3'h2, 3'h3};
  logic [2:0] idx = 3'h0;
  logic [2:0] last;

  assign last = three_ph_i ? 3'h5 : 3'h3;

  ////////////////////////////////////////////////////////////////////////
  // Only neighbouring states are issued, so each step is one legal edge
  always_ff @(posedge clk_i) begin
    if (step_i && cw_i) begin
      idx <= (idx >= last) ? 3'h0 : idx + 3'h1;
    end else if (step_i) begin
      idx <= (idx == 3'h0 || idx > last) ? last : idx - 3'h1;
    end
  end

  // W stays low in two-phase use; the block ignores it then
  assign {u_o, v_o, w_o} = three_ph_i ? P3[idx] : P2[idx[1:0]];
endmodule // hspc_hall_model

`default_nettype wire

// [hall_sensor_timer_position_counter_test.sv]
// Self-checking bench for the Hall sensor position counter
`timescale 1ns/1ps
`default_nettype none
`include "hspc_defs.svh"

module hall_sensor_timer_position_counter_test import hspc_pkg::*;;
  localparam logic [7:0] ctl = `HSPC_OFF_CTRL;
  localparam logic [7:0] cmd = `HSPC_OFF_CMD;
  localparam logic [7:0] cmpr = `HSPC_OFF_COMPARE;
  localparam logic [7:0] rld = `HSPC_OFF_RELOAD;
  localparam logic [7:0] cnt = `HSPC_OFF_COUNTER;
  localparam logic [7:0] cap = `HSPC_OFF_CAPTURE;
  localparam logic [7:0] sta = `HSPC_OFF_STATUS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic u, v, w;
  logic z = 1'b0, stp = 1'b0, dcw = 1'b1, tp = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, d, c1;
  logic [1:0] br, rr;
  wire div_o, dir_o, irq_o, awr, wr_r, bv, arr_o, rv;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int errors = 0, checks_done = 0, nirq = 0, ndiv = 0, n0, n1;

  hspc_top i_dut (.SYS_CLK_I(clk), .RESET_I(rst), .ENC_U_I(u), .ENC_V_I(v), .ENC_W_I(w), .ENC_Z_I(z),
    .DIV_PULSE_O(div_o), .DIRECTION_O(dir_o), .IRQ_O(irq_o), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr_o), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre));

  hspc_hall_model i_hall (.clk_i(clk), .step_i(stp), .cw_i(dcw), .three_ph_i(tp), .u_o(u), .v_o(v),
    .w_o(w));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // One-cycle pulses are counted at every edge so none slips between checks
  always @(posedge clk) begin
    if (irq_o === 1'b1) nirq++;
    if (div_o === 1'b1) ndiv++;
  end

  ////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task tmo(input int n);
    if (n >= 50) begin
      errors++;
      conclude;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] x);
    int n;
    awa <= a;
    wd <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv) break;
    end
    bre <= 1'b0;
    br = bresp;
    tmo(n);
    // Lets registered side effects reach the pins before anyone looks
    repeat (2) @(posedge clk);
  endtask

  task rd(input logic [7:0] a);
    int n;
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arv && arr_o) arv <= 1'b0;
      if (rv) break;
    end
    rre <= 1'b0;
    d = rdata;
    rr = rresp;
    tmo(n);
    // One idle edge so a following read never lowers and raises rready in one step
    @(posedge clk);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask

  // Ten cycles per step keeps every pin state well past the three-cycle minimum
  task st(input logic c, input int k);
    dcw <= c;
    repeat (k) begin
      @(posedge clk);
      stp <= 1'b1;
      @(posedge clk);
      stp <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    rc(ctl, 32'h0);
    rc(cmpr, 32'h0);
    rc(rld, 32'hFFFF);
    rc(cnt, 32'h0);
    rc(cap, 32'h0);
    rc(sta, 32'h0);
    rc(8'h40, 32'h0);
    chk(rr, `HSPC_RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk(br, `HSPC_RESP_SLVERR);
    wr(cnt, 32'h5);
    rc(cnt, 32'h0);
  endtask

  task t_event;
    wr(cmpr, 32'h2);
    wr(ctl, 32'h1C3);
    n0 = nirq;
    n1 = ndiv;
    st(1'b1, 4);
    rc(cnt, 32'h4);
    chk(nirq - n0, 32'h1);
    chk(ndiv - n1, 32'h2);
    chk(dir_o, 1'b1);
    wr(cmd, 32'h1);
    rc(cnt, 32'h0);
    st(1'b0, 1);
    rc(cnt, 32'hFFFF);
    chk(dir_o, 1'b0);
    st(1'b1, 1);
    rc(cnt, 32'h0);
  endtask

  task t_run;
    wr(ctl, 32'h1C2);
    chk(dir_o, 1'b0);
    st(1'b1, 2);
    rc(cnt, 32'h0);
    wr(ctl, 32'h1C3);
    st(1'b1, 1);
    rc(cnt, 32'h1);
  endtask

  task t_three;
    tp <= 1'b1;
    wr(ctl, 32'h0B);
    wr(cmd, 32'h1);
    st(1'b1, 6);
    rc(cnt, 32'h6);
    tp <= 1'b0;
  endtask

  task t_stc;
    wr(ctl, 32'h5);
    st(1'b1, 1);
    rd(sta);
    st(1'b1, 3);
    rd(cap);
    chk(d - 32'h9 < 32'h2, 1'b1);
    rc(sta, 32'h1);
    st(1'b0, 1);
    rc(sta, 32'h2);
    rc(sta, 32'h0);
    repeat (40) @(posedge clk);
    wr(cmd, 32'h2);
    rd(cap);
    chk(d > 32'h20, 1'b1);
    c1 = d;
    wr(ctl, 32'h4);
    rc(cap, c1);
  endtask

  task t_timer;
    // Start from zero, else the held count sits above the compare value for 2^24 cycles
    wr(cmd, 32'h1);
    wr(cmpr, 32'h14);
    wr(ctl, 32'h47);
    n0 = nirq;
    repeat (210) @(posedge clk);
    chk(nirq - n0, 32'hA);
    rd(cnt);
    chk(d < 32'h15, 1'b1);
    wr(ctl, 32'h7);
    rd(cnt);
    c1 = d;
    repeat (100) @(posedge clk);
    rd(cnt);
    chk(d - c1 - 32'h64 < 32'h10, 1'b1);
  endtask

  task t_tz;
    rd(cap);
    c1 = d;
    wr(cmd, 32'h1);
    repeat (60) @(posedge clk);
    z <= 1'b1;
    repeat (10) @(posedge clk);
    rd(cnt);
    chk(d > 32'h40, 1'b1);
    rc(cap, c1);
    wr(ctl, 32'h37);
    repeat (60) @(posedge clk);
    z <= 1'b0;
    repeat (10) @(posedge clk);
    rd(cnt);
    chk(d < 32'h20, 1'b1);
    rd(cap);
    chk(d > 32'h40, 1'b1);
    wr(ctl, 32'h17);
    repeat (60) @(posedge clk);
    z <= 1'b1;
    repeat (10) @(posedge clk);
    rd(cnt);
    chk(d < 32'h20, 1'b1);
  endtask

  task t_enc;
    wr(rld, 32'h3);
    wr(ctl, 32'h1);
    wr(cmd, 32'h1);
    st(1'b1, 4);
    rc(cnt, 32'h0);
    st(1'b0, 1);
    rc(cnt, 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_event;
    t_run;
    t_three;
    t_stc;
    t_timer;
    t_tz;
    t_enc;
    conclude;
  end
endmodule // hall_sensor_timer_position_counter_test

`default_nettype wire
